/* File: inc/pwm_timer_regs.svh */
// Register map, field positions and reset values of the PWM timer
`ifndef PWM_TIMER_REGS_SVH
`define PWM_TIMER_REGS_SVH

`define PT_NUM_MATCH      7
`define PT_NUM_OUT        6
`define PT_NUM_CAP        2
`define PT_WORD_BYTES     4
`define PT_ADDR_W         7

`define PT_OFF_INT_STAT   7'h00
`define PT_OFF_TMR_CTRL   7'h04
`define PT_OFF_COUNT      7'h08
`define PT_OFF_PRE_LIM    7'h0c
`define PT_OFF_PRE_CNT    7'h10
`define PT_OFF_MATCH_CTRL 7'h14
`define PT_OFF_MATCH0     7'h18
`define PT_OFF_CAP_CTRL   7'h34
`define PT_OFF_CAP0       7'h38
`define PT_OFF_CNT_CTRL   7'h40
`define PT_OFF_PWM_CTRL   7'h44
`define PT_OFF_RELEASE    7'h48
`define PT_OFF_INT_MASK   7'h4c

`define PT_CTRL_EN        0
`define PT_CTRL_RST       1
`define PT_CTRL_PWM       3
`define PT_CTRL_W         4

`define PT_MC_INT         0
`define PT_MC_RST         1
`define PT_MC_STOP        2
`define PT_MC_W           3

`define PT_CC_RISE        0
`define PT_CC_FALL        1
`define PT_CC_INT         2
`define PT_CC_W           3

`define PT_CNT_SEL        2
`define PT_CNT_W          3
`define PT_PWM_EN_LSB     8
`define PT_PWM_W          15
`define PT_INT_CAP_LSB    8
`define PT_INT_W          10

`define PT_RST_WORD       32'h0000_0000
`define PT_ONE_WORD       32'h0000_0001

`endif

/* File: inc/pwm_timer_pkg.sv */
// Types shared by the PWM timer design files
package pwm_timer_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        CNT_TIMER,
        CNT_RISE,
        CNT_FALL,
        CNT_BOTH
    } count_mode_t;
endpackage

/* File: hdl/cap_edge_detect.sv */
// Capture pin synchroniser and edge detector
`timescale 1ns/1ps
`include "pwm_timer_regs.svh"
module cap_edge_detect
    import pwm_timer_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic [`PT_NUM_CAP-1:0] pin_i,
    output logic      [`PT_NUM_CAP-1:0] rise_o,
    output logic      [`PT_NUM_CAP-1:0] fall_o
);
    logic [`PT_NUM_CAP-1:0] meta_r;
    logic [`PT_NUM_CAP-1:0] sync_r;
    logic [`PT_NUM_CAP-1:0] last_r;
    logic [`PT_NUM_CAP-1:0] rise_nxt;
    logic [`PT_NUM_CAP-1:0] fall_nxt;
    logic [`PT_NUM_CAP-1:0] rise_r;
    logic [`PT_NUM_CAP-1:0] fall_r;

    // Edges come only from the second and third stages
    always_comb begin
        rise_nxt = sync_r & ~last_r;
        fall_nxt = ~sync_r & last_r;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
            rise_r <= '0;
            fall_r <= '0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            last_r <= sync_r;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign rise_o = rise_r;
    assign fall_o = fall_r;
endmodule

/* File: hdl/pwm_timer.sv */
// Multi-output PWM timer with Avalon-MM register slave
// Function
// - Seven match registers serve six single-edge or three double-edge outputs.
// - Match on cycle_period_match resets the count, setting the shared period.
// - A single-edge output falls on its own one extra match register.
// - Every single-edge output rises when cycle_period_match matches.
// - A single-edge output programmed constantly low never rises.
// - A double-edge output rises on one match and falls on another.
// - Rise before fall gives a positive pulse, else a negative pulse.
// - Period and width take any count; all outputs share one rate.
// - Released match values take effect only at the cycle boundary.
// - Each match may keep counting, stop or reset, with optional interrupt.
// - Count clock cycles, or transitions on a selected capture input.
// - With PWM off it is a plain timer with 32-bit prescaler, outputs low.
// - A capture input transition copies the count, optional interrupt.
`timescale 1ns/1ps
`include "pwm_timer_regs.svh"
module pwm_timer
    import pwm_timer_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic [`PT_ADDR_W-1:0]  avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic      [31:0]            avs_readdata_o,
    output logic                        avs_waitrequest_o,
    input  wire logic [`PT_NUM_CAP-1:0] cap_pin_i,
    output logic      [`PT_NUM_OUT-1:0] pwm_o,
    output logic                        irq_o
);
    logic                                   ack_r, ack_nxt;
    word_t                                  rdata_r, rdata_nxt;
    logic [`PT_CTRL_W-1:0]                  tmr_ctrl_r, tmr_ctrl_nxt;
    word_t                                  tc_r, tc_nxt;
    word_t                                  pc_r, pc_nxt;
    word_t                                  pre_lim_r, pre_lim_nxt;
    logic [`PT_NUM_MATCH*`PT_MC_W-1:0]      mctrl_r, mctrl_nxt;
    word_t                                  shadow_r [`PT_NUM_MATCH];
    word_t                                  shadow_nxt [`PT_NUM_MATCH];
    word_t                                  active_r [`PT_NUM_MATCH];
    word_t                                  active_nxt [`PT_NUM_MATCH];
    logic [`PT_NUM_MATCH-1:0]               release_r, release_nxt;
    logic [`PT_NUM_CAP*`PT_CC_W-1:0]        cctrl_r, cctrl_nxt;
    word_t                                  cap_r [`PT_NUM_CAP];
    word_t                                  cap_nxt [`PT_NUM_CAP];
    logic [`PT_CNT_W-1:0]                   cnt_ctrl_r, cnt_ctrl_nxt;
    logic [`PT_PWM_W-1:0]                   pwm_ctrl_r, pwm_ctrl_nxt;
    logic [`PT_INT_W-1:0]                   int_stat_r, int_stat_nxt;
    logic [`PT_INT_W-1:0]                   int_mask_r, int_mask_nxt;
    logic [`PT_NUM_OUT-1:0]                 pwm_r, pwm_nxt;

    logic [`PT_NUM_CAP-1:0]                 cap_rise, cap_fall, cap_ev;
    logic [`PT_NUM_MATCH-1:0]               hit;
    logic                                   wr, rd_go, pwm_en, run;
    logic                                   cnt_evt, tick, do_reset, do_stop;
    logic                                   sel_edge_r, sel_edge_f;
    word_t                                  rd_val;
    count_mode_t                            mode;

    cap_edge_detect i_cap_edge_detect (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .pin_i  (cap_pin_i),
        .rise_o (cap_rise),
        .fall_o (cap_fall)
    );

    function automatic logic [`PT_ADDR_W-1:0] match_addr(input int i);
        match_addr = `PT_OFF_MATCH0 + `PT_ADDR_W'(`PT_WORD_BYTES * i);
    endfunction

    function automatic logic [`PT_ADDR_W-1:0] cap_addr(input int i);
        cap_addr = `PT_OFF_CAP0 + `PT_ADDR_W'(`PT_WORD_BYTES * i);
    endfunction

    function automatic word_t merge(input word_t old, input word_t nw,
                                    input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // Bus: one wait cycle, so writes land and reads answer on the 2nd edge
    always_comb begin
        wr        = avs_write_i & ack_r;
        rd_go     = avs_read_i & ~ack_r;
        ack_nxt   = (avs_read_i | avs_write_i) & ~ack_r;
        rd_val    = `PT_RST_WORD;
        case (avs_address_i)
            `PT_OFF_INT_STAT:   rd_val[`PT_INT_W-1:0] = int_stat_r;
            `PT_OFF_TMR_CTRL:   rd_val[`PT_CTRL_W-1:0] = tmr_ctrl_r;
            `PT_OFF_COUNT:      rd_val = tc_r;
            `PT_OFF_PRE_LIM:    rd_val = pre_lim_r;
            `PT_OFF_PRE_CNT:    rd_val = pc_r;
            `PT_OFF_MATCH_CTRL: rd_val[`PT_NUM_MATCH*`PT_MC_W-1:0] = mctrl_r;
            `PT_OFF_CAP_CTRL:   rd_val[`PT_NUM_CAP*`PT_CC_W-1:0] = cctrl_r;
            `PT_OFF_CNT_CTRL:   rd_val[`PT_CNT_W-1:0] = cnt_ctrl_r;
            `PT_OFF_PWM_CTRL:   rd_val[`PT_PWM_W-1:0] = pwm_ctrl_r;
            `PT_OFF_RELEASE:    rd_val[`PT_NUM_MATCH-1:0] = release_r;
            `PT_OFF_INT_MASK:   rd_val[`PT_INT_W-1:0] = int_mask_r;
            default:            rd_val = `PT_RST_WORD;
        endcase
        for (int i = 0; i < `PT_NUM_MATCH; i++) begin
            if (avs_address_i == match_addr(i)) begin
                rd_val = shadow_r[i];
            end
        end
        for (int c = 0; c < `PT_NUM_CAP; c++) begin
            if (avs_address_i == cap_addr(c)) begin
                rd_val = cap_r[c];
            end
        end
        rdata_nxt = rd_go ? rd_val : rdata_r;
    end

    // Counting source, prescaler and match decisions
    always_comb begin
        pwm_en     = tmr_ctrl_r[`PT_CTRL_PWM];
        run        = tmr_ctrl_r[`PT_CTRL_EN] & ~tmr_ctrl_r[`PT_CTRL_RST];
        mode       = count_mode_t'(cnt_ctrl_r[1:0]);
        sel_edge_r = cap_rise[cnt_ctrl_r[`PT_CNT_SEL]];
        sel_edge_f = cap_fall[cnt_ctrl_r[`PT_CNT_SEL]];
        case (mode)
            CNT_TIMER: cnt_evt = 1'b1;
            CNT_RISE:  cnt_evt = sel_edge_r;
            CNT_FALL:  cnt_evt = sel_edge_f;
            CNT_BOTH:  cnt_evt = sel_edge_r | sel_edge_f;
            default:   cnt_evt = 1'b0;
        endcase
        tick     = run & cnt_evt & (pc_r == pre_lim_r);
        do_reset = pwm_en & 1'b0;
        do_stop  = 1'b0;
        for (int i = 0; i < `PT_NUM_MATCH; i++) begin
            hit[i] = tick & (tc_r == active_r[i]);
            do_reset = do_reset | (hit[i] & mctrl_r[i*`PT_MC_W+`PT_MC_RST]);
            do_stop  = do_stop | (hit[i] & mctrl_r[i*`PT_MC_W+`PT_MC_STOP]);
        end
        do_reset = do_reset | (pwm_en & hit[0]);
    end

    // Timer, prescaler and control registers
    always_comb begin
        tmr_ctrl_nxt = tmr_ctrl_r;
        pre_lim_nxt  = pre_lim_r;
        mctrl_nxt    = mctrl_r;
        cctrl_nxt    = cctrl_r;
        cnt_ctrl_nxt = cnt_ctrl_r;
        pwm_ctrl_nxt = pwm_ctrl_r;
        int_mask_nxt = int_mask_r;
        pc_nxt       = pc_r;
        tc_nxt       = tc_r;
        if (run & cnt_evt) begin
            pc_nxt = (pc_r == pre_lim_r) ? `PT_RST_WORD : pc_r + `PT_ONE_WORD;
        end
        if (tick) begin
            tc_nxt = do_reset ? `PT_RST_WORD : tc_r + `PT_ONE_WORD;
        end
        if (tmr_ctrl_r[`PT_CTRL_RST]) begin
            tc_nxt = `PT_RST_WORD;
            pc_nxt = `PT_RST_WORD;
        end
        if (do_stop) begin
            tmr_ctrl_nxt[`PT_CTRL_EN] = 1'b0;
        end
        if (wr) begin
            case (avs_address_i)
                `PT_OFF_TMR_CTRL: tmr_ctrl_nxt = `PT_CTRL_W'(
                    merge(word_t'(tmr_ctrl_r), avs_writedata_i,
                          avs_byteenable_i));
                `PT_OFF_COUNT:    tc_nxt = merge(tc_r, avs_writedata_i,
                                                 avs_byteenable_i);
                `PT_OFF_PRE_LIM:  pre_lim_nxt = merge(pre_lim_r,
                                      avs_writedata_i, avs_byteenable_i);
                `PT_OFF_PRE_CNT:  pc_nxt = merge(pc_r, avs_writedata_i,
                                                 avs_byteenable_i);
                `PT_OFF_MATCH_CTRL: mctrl_nxt =
                    (`PT_NUM_MATCH*`PT_MC_W)'(merge(word_t'(mctrl_r),
                          avs_writedata_i, avs_byteenable_i));
                `PT_OFF_CAP_CTRL: cctrl_nxt =
                    (`PT_NUM_CAP*`PT_CC_W)'(merge(word_t'(cctrl_r),
                          avs_writedata_i, avs_byteenable_i));
                `PT_OFF_CNT_CTRL: cnt_ctrl_nxt = `PT_CNT_W'(
                    merge(word_t'(cnt_ctrl_r), avs_writedata_i,
                          avs_byteenable_i));
                `PT_OFF_PWM_CTRL: pwm_ctrl_nxt = `PT_PWM_W'(
                    merge(word_t'(pwm_ctrl_r), avs_writedata_i,
                          avs_byteenable_i));
                `PT_OFF_INT_MASK: int_mask_nxt = `PT_INT_W'(
                    merge(word_t'(int_mask_r), avs_writedata_i,
                          avs_byteenable_i));
                default: ;
            endcase
        end
    end

    // Match shadows, release and capture; set always beats clear
    always_comb begin
        int_stat_nxt = int_stat_r;
        if (wr && avs_address_i == `PT_OFF_INT_STAT) begin
            int_stat_nxt = int_stat_r & ~avs_writedata_i[`PT_INT_W-1:0];
        end
        release_nxt = release_r;
        for (int i = 0; i < `PT_NUM_MATCH; i++) begin
            shadow_nxt[i] = shadow_r[i];
            active_nxt[i] = active_r[i];
            // Mid-cycle writes would glitch outputs, so wait for the wrap
            if (!pwm_en || (hit[0] && release_r[i])) begin
                active_nxt[i]  = shadow_r[i];
                release_nxt[i] = 1'b0;
            end
            if (wr && avs_address_i == match_addr(i)) begin
                shadow_nxt[i] = merge(shadow_r[i], avs_writedata_i,
                                      avs_byteenable_i);
            end
            if (hit[i] && mctrl_r[i*`PT_MC_W+`PT_MC_INT]) begin
                int_stat_nxt[i] = 1'b1;
            end
        end
        if (wr && avs_address_i == `PT_OFF_RELEASE) begin
            release_nxt = release_nxt | avs_writedata_i[`PT_NUM_MATCH-1:0];
        end
        for (int c = 0; c < `PT_NUM_CAP; c++) begin
            cap_ev[c] = (cap_rise[c] & cctrl_r[c*`PT_CC_W+`PT_CC_RISE]) |
                        (cap_fall[c] & cctrl_r[c*`PT_CC_W+`PT_CC_FALL]);
            cap_nxt[c] = cap_ev[c] ? tc_r : cap_r[c];
            if (cap_ev[c] && cctrl_r[c*`PT_CC_W+`PT_CC_INT]) begin
                int_stat_nxt[`PT_INT_CAP_LSB+c] = 1'b1;
            end
        end
    end

    // Outputs: output k clears on match k+1, sets on match 0 or match k
    always_comb begin
        for (int k = 0; k < `PT_NUM_OUT; k++) begin
            pwm_nxt[k] = pwm_r[k];
            if (k > 0 && pwm_ctrl_r[k+1]) begin
                if (hit[k]) pwm_nxt[k] = 1'b1;
            end else if (hit[0]) begin
                pwm_nxt[k] = 1'b1;
            end
            if (hit[k+1]) pwm_nxt[k] = 1'b0;
            if (!pwm_en || !pwm_ctrl_r[`PT_PWM_EN_LSB+k+1]) begin
                pwm_nxt[k] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ack_r      <= 1'b0;
            rdata_r    <= `PT_RST_WORD;
            tmr_ctrl_r <= '0;
            tc_r       <= `PT_RST_WORD;
            pc_r       <= `PT_RST_WORD;
            pre_lim_r  <= `PT_RST_WORD;
            mctrl_r    <= '0;
            release_r  <= '0;
            cctrl_r    <= '0;
            cnt_ctrl_r <= '0;
            pwm_ctrl_r <= '0;
            int_stat_r <= '0;
            int_mask_r <= '0;
            pwm_r      <= '0;
            for (int i = 0; i < `PT_NUM_MATCH; i++) begin
                shadow_r[i] <= `PT_RST_WORD;
                active_r[i] <= `PT_RST_WORD;
            end
            for (int c = 0; c < `PT_NUM_CAP; c++) begin
                cap_r[c] <= `PT_RST_WORD;
            end
        end else begin
            ack_r      <= ack_nxt;
            rdata_r    <= rdata_nxt;
            tmr_ctrl_r <= tmr_ctrl_nxt;
            tc_r       <= tc_nxt;
            pc_r       <= pc_nxt;
            pre_lim_r  <= pre_lim_nxt;
            mctrl_r    <= mctrl_nxt;
            release_r  <= release_nxt;
            cctrl_r    <= cctrl_nxt;
            cnt_ctrl_r <= cnt_ctrl_nxt;
            pwm_ctrl_r <= pwm_ctrl_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            pwm_r      <= pwm_nxt;
            shadow_r   <= shadow_nxt;
            active_r   <= active_nxt;
            cap_r      <= cap_nxt;
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
    assign avs_readdata_o    = rdata_r;
    assign pwm_o             = pwm_r;
    assign irq_o             = |(int_stat_r & int_mask_r);

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_period_wrap: assert property (
        pwm_en && hit[0] && !tmr_ctrl_r[`PT_CTRL_RST] && !wr
        |=> tc_r == `PT_RST_WORD)
        else $error("count did not wrap on period match");
    a_single_rise: assert property (
        pwm_en && pwm_ctrl_r[`PT_PWM_EN_LSB+1] && hit[0] && !hit[1]
        && !wr |=> pwm_o[0])
        else $error("single-edge output did not rise at cycle start");
    a_const_low: assert property (
        hit[1] ##1 !hit[0] [*2] |-> !pwm_o[0] && $past(!pwm_o[0]))
        else $error("single-edge output rose after its clearing match");
    a_double_rise: assert property (
        pwm_en && pwm_ctrl_r[2] && pwm_ctrl_r[`PT_PWM_EN_LSB+2]
        && hit[1] && !hit[2] && !wr |=> pwm_o[1])
        else $error("double-edge output missed its rising match");
    a_pwm_off_low: assert property (
        !pwm_en ##1 !pwm_en |-> pwm_o == '0)
        else $error("output active with pwm mode off");
    a_release_hold: assert property (
        pwm_en && !hit[0] |=> active_r[1] == $past(active_r[1]))
        else $error("match value changed inside a pwm cycle");
    a_prescale_step: assert property (
        tick && !do_reset && !wr && !tmr_ctrl_r[`PT_CTRL_RST]
        |=> tc_r == $past(tc_r) + `PT_ONE_WORD && pc_r == `PT_RST_WORD)
        else $error("count did not advance at prescale limit");
    a_stop_match: assert property (
        do_stop && !wr |=> !tmr_ctrl_r[`PT_CTRL_EN]
        ##1 ($past(wr) || $stable(tc_r)))
        else $error("timer kept running after stop match");
    a_capture_copy: assert property (
        cap_ev[0] |=> cap_r[0] == $past(tc_r))
        else $error("capture register missed the count");
endmodule

/* File: test/pwm_load_model.sv */
// Load model: counts on-cycles of each output and makes sensor pulses
`timescale 1ns/1ps
module pwm_load_model (
    input  wire logic       clk_i,
    input  wire logic [5:0] pwm_i,
    input  wire logic       clr_i,
    output logic      [1:0] sense_o
);
    int on_cnt [6];
    initial sense_o = 2'h0;
    always @(posedge clk_i) begin
        for (int k = 0; k < 6; k++) begin
            if (clr_i)
                on_cnt[k] <= 0;
            else if (pwm_i[k] === 1'b1)
                on_cnt[k] <= on_cnt[k] + 1;
        end
    end
    // Each level lasts 3 clocks, so the pin synchroniser sees every edge
    task automatic pulse(input int n);
        repeat (n) begin
            sense_o <= 2'h1;
            repeat (3) @(posedge clk_i);
            sense_o <= 2'h0;
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule

/* File: test/multi_output_pwm_timer_tb_top.sv */
// Self-checking bench for the multi-output PWM timer
`timescale 1ns/1ps
`include "pwm_timer_regs.svh"
module multi_output_pwm_timer_tb_top
    import pwm_timer_pkg::*;
;
    logic       clk_i;
    logic       nrst_i;
    logic [6:0] adr;
    logic       rd_en;
    logic       wr_en;
    word_t      wdat;
    word_t      rdat;
    logic       wait_req;
    logic [1:0] cap_pin;
    logic [5:0] pwm_o;
    logic [5:0] pwm_q;
    logic       irq_o;
    logic       clr;
    logic       rise_chk;
    int         errors;
    int         tests_run;
    word_t      v;
    int         c0;
    int         c1;

    pwm_timer i_pwm_timer (.clk_i(clk_i), .nrst_i(nrst_i),
        .avs_address_i(adr), .avs_read_i(rd_en), .avs_write_i(wr_en),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
        .cap_pin_i(cap_pin), .pwm_o(pwm_o), .irq_o(irq_o));
    pwm_load_model i_pwm_load_model (.clk_i(clk_i), .pwm_i(pwm_o),
        .clr_i(clr), .sense_o(cap_pin));

    task automatic chk(input string nm, input word_t e, input word_t g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // The request stays up until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [6:0] a, input word_t d,
                       output word_t q);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        rd_en <= ~w;
        wr_en <= w;
        @(posedge clk_i);
        while (wait_req !== 1'b0 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 100) begin
            errors++;
            $display("ERROR bus_wait expected 0 seen 1");
        end
        q = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [6:0] a, input word_t d);
        word_t q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [6:0] a, output word_t q);
        bus(1'b0, a, 32'h0, q);
    endtask
    function automatic logic [6:0] mr(input int i);
        return 7'(`PT_OFF_MATCH0 + 4 * i);
    endfunction
    function automatic word_t on(input int k);
        return 32'(i_pwm_load_model.on_cnt[k]);
    endfunction
    // Whole periods in the window make the count independent of phase
    task automatic win(input int n);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (n + 1) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        pwm_q <= pwm_o;
        if (rise_chk && ((pwm_o[0] & ~pwm_q[0]) !== (pwm_o[2] & ~pwm_q[2])))
        begin
            errors++;
            $display("ERROR rise_align expected %h seen %h",
                     pwm_o[0], pwm_o[2]);
        end
    end

    task automatic t_reset();
        logic [6:0] regs [7] = '{`PT_OFF_INT_STAT, `PT_OFF_TMR_CTRL,
            `PT_OFF_COUNT, `PT_OFF_PRE_LIM, `PT_OFF_PRE_CNT, mr(0), `PT_OFF_CAP0};
        foreach (regs[k]) begin
            rd(regs[k], v);
            chk("reset_reg", 32'h0, v);
        end
        wr(7'h7c, 32'hffff_ffff);
        rd(7'h7c, v);
        chk("unmapped", 32'h0, v);
        chk("pwm_idle", 32'h0, {26'h0, pwm_o});
        $display("Test reset done");
    endtask
    task automatic t_single();
        wr(`PT_OFF_PRE_LIM, 32'h0);
        wr(mr(0), 32'h9);
        wr(mr(1), 32'h3);
        wr(mr(2), 32'h9);
        wr(mr(3), 32'h6);
        wr(`PT_OFF_PWM_CTRL, 32'h0e00);
        wr(`PT_OFF_TMR_CTRL, 32'h9);
        repeat (12) @(posedge clk_i);
        rise_chk <= 1'b1;
        win(40);
        rise_chk <= 1'b0;
        tests_run++;
        chk("out1_on", 32'd16, on(0));
        chk("out2_on", 32'd0, on(1));
        chk("out3_on", 32'd28, on(2));
        $display("Test single edge done");
    endtask
    // Release takes effect at the next boundary, and the flag clears on that same edge
    task automatic rel();
        int n;
        n = 0;
        wr(`PT_OFF_RELEASE, 32'h6);
        v = 32'h6;
        while (v !== 32'h0 && n < 20) begin
            rd(`PT_OFF_RELEASE, v);
            n++;
        end
        chk("release_done", 32'h0, v);
    endtask
    task automatic t_double();
        wr(`PT_OFF_PWM_CTRL, 32'h0404);
        wr(mr(1), 32'h2);
        wr(mr(2), 32'h7);
        rel();
        win(40);
        chk("pos_pulse", 32'd20, on(1));
        wr(mr(1), 32'h8);
        wr(mr(2), 32'h2);
        win(40);
        chk("unreleased", 32'd20, on(1));
        rel();
        win(40);
        chk("neg_pulse", 32'd16, on(1));
        $display("Test double edge done");
    endtask
    task automatic run(input word_t lim, output int c);
        wr(`PT_OFF_INT_STAT, 32'hffff_ffff);
        wr(`PT_OFF_COUNT, 32'h0);
        wr(`PT_OFF_PRE_CNT, 32'h0);
        wr(`PT_OFF_PRE_LIM, lim);
        wr(`PT_OFF_TMR_CTRL, 32'h1);
        c = 0;
        while (irq_o !== 1'b1 && c < 200) begin
            @(posedge clk_i);
            c++;
        end
    endtask
    task automatic t_match();
        wr(`PT_OFF_TMR_CTRL, 32'h0);
        wr(`PT_OFF_MATCH_CTRL, 32'h0a00);
        wr(mr(3), 32'h2);
        wr(`PT_OFF_INT_MASK, 32'h8);
        run(32'h0, c0);
        run(32'h3, c1);
        chk("prescale", 32'd9, 32'(c1 - c0));
        rd(`PT_OFF_TMR_CTRL, v);
        chk("stop_clr", 32'h0, v);
        chk("pwm_off", 32'h0, {26'h0, pwm_o});
        wr(`PT_OFF_INT_MASK, 32'h0);
        chk("irq_mask", 32'h0, {31'h0, irq_o});
        rd(`PT_OFF_INT_STAT, v);
        chk("stat_sticky", 32'h8, v);
        wr(`PT_OFF_INT_MASK, 32'h8);
        chk("irq_on", 32'h1, {31'h0, irq_o});
        wr(`PT_OFF_INT_STAT, 32'h8);
        chk("irq_clr", 32'h0, {31'h0, irq_o});
        $display("Test match done");
    endtask
    task automatic t_cap();
        wr(`PT_OFF_MATCH_CTRL, 32'h0);
        wr(`PT_OFF_TMR_CTRL, 32'h0);
        wr(`PT_OFF_COUNT, 32'h0);
        wr(`PT_OFF_PRE_CNT, 32'h0);
        wr(`PT_OFF_PRE_LIM, 32'h0);
        wr(`PT_OFF_CAP_CTRL, 32'h5);
        wr(`PT_OFF_INT_MASK, 32'h100);
        wr(`PT_OFF_CNT_CTRL, 32'h1);
        wr(`PT_OFF_TMR_CTRL, 32'h1);
        i_pwm_load_model.pulse(5);
        repeat (6) @(posedge clk_i);
        rd(`PT_OFF_COUNT, v);
        chk("edge_count", 32'd5, v);
        rd(`PT_OFF_CAP0, v);
        chk("capture", 32'd4, v);
        chk("cap_irq", 32'h1, {31'h0, irq_o});
        // Both-edge mode: two pulses give four more counts
        wr(`PT_OFF_CNT_CTRL, 32'h3);
        i_pwm_load_model.pulse(2);
        repeat (6) @(posedge clk_i);
        rd(`PT_OFF_COUNT, v);
        chk("both_edges", 32'd9, v);
        $display("Test capture done");
    endtask
    // Reset in mid-run must wipe what the earlier tests left behind
    task automatic t_mid_reset();
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rd(`PT_OFF_COUNT, v);
        chk("rst_count", 32'h0, v);
        rd(`PT_OFF_CAP0, v);
        chk("rst_cap", 32'h0, v);
        rd(`PT_OFF_TMR_CTRL, v);
        chk("rst_ctrl", 32'h0, v);
        chk("rst_irq", 32'h0, {31'h0, irq_o});
        $display("Test mid reset done");
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // The whole run needs fewer than 500 clocks
    initial begin
        #500us;
        errors++;
        print_verdict();
    end
    initial begin
        nrst_i = 1'b0;
        adr = 7'h0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdat = 32'h0;
        clr = 1'b0;
        rise_chk = 1'b0;
        errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_single();
        t_double();
        t_match();
        t_cap();
        t_mid_reset();
        print_verdict();
    end
endmodule
